/* File: core/gpcp_defs.vh */
// Constants for the eight-pin general purpose port with change detect.
// Assumes inclusion by gpcp_port.v and the bench; holds definitions, no logic.
`ifndef GPCP_DEFS_VH
`define GPCP_DEFS_VH

// ==========================================================================
// Register byte offsets on the AXI4-Lite bus
`define GPCP_OFS_DATA     5'h00
`define GPCP_OFS_DIR      5'h04
`define GPCP_OFS_ANSEL    5'h08
`define GPCP_OFS_PULLUP   5'h0c
`define GPCP_OFS_CHGEN    5'h10
`define GPCP_OFS_OPTION   5'h14
`define GPCP_OFS_INTCTL   5'h18

// ==========================================================================
// Field positions
`define GPCP_OPT_PUDIS_BIT    3'h7
`define GPCP_INT_FLAG_BIT     3'h0
`define GPCP_INT_ENA_BIT      3'h3

// ==========================================================================
// Reset values
`define GPCP_RST_DIR      8'hff
`define GPCP_RST_ANSEL    8'hff
`define GPCP_RST_PULLUP   8'h00
`define GPCP_RST_CHGEN    8'h00
`define GPCP_RST_LATCH    8'h00
`define GPCP_RST_PUDIS    1'h1

// ==========================================================================
// Bus answers
`define GPCP_RESP_OKAY    2'h0
`define GPCP_RESP_SLVERR  2'h2
`define GPCP_ZERO32       32'h0000_0000
`define GPCP_ZERO8        8'h00

`endif

/* File: core/gpcp_port.v */
// Eight-pin bidirectional port with direction, analog select, pull-ups
// and interrupt-on-change, reached over AXI4-Lite.
// Assumes one clock; pins arrive asynchronously; the second reset comes
// from master-clear / brown-out logic already on aclk.
`timescale 1ns/1ps
`include "gpcp_defs.vh"
`default_nettype none

// Behaviour
// - Eight-bit port, each pin input or output
// - Direction one tri-states, zero drives latch
// - Read returns pins, write updates latch
// - Writes sample pins, then store latch
// - Direction still drives analog pins
// - Analog-selected pins read as zero
// - Analog select never affects digital output
// - Per-pin pull-up enable mask
// - Pull-up off while pin is output
// - Global pull-up disable, set at power-on
// - Per-pin change interrupt enable mask
// - Power-on leaves change detect disabled
// - Compare pins against last-read latch
// - OR mismatches to set change flag
// - Change flag can wake from sleep
// - Persistent mismatch keeps re-setting flag
// - Soft resets keep last-read latch
// - Change during read still sets flag
module gpcp_port #(
    parameter WIDTH = 8                     // Port pin count
) (
    input  wire              aclk,          // Core clock, 10 MHz
    input  wire              aresetn,       // Power-on reset, sync, low
    input  wire              soft_resetn,   // Master-clear / brown-out, low
    // AXI4-Lite write address
    input  wire [4:0]        awaddr,
    input  wire              awvalid,
    output wire              awready,
    // AXI4-Lite write data
    input  wire [31:0]       wdata,
    input  wire [3:0]        wstrb,
    input  wire              wvalid,
    output wire              wready,
    // AXI4-Lite write response
    output wire [1:0]        bresp,
    output wire              bvalid,
    input  wire              bready,
    // AXI4-Lite read address
    input  wire [4:0]        araddr,
    input  wire              arvalid,
    output wire              arready,
    // AXI4-Lite read data
    output wire [31:0]       rdata,
    output wire [1:0]        rresp,
    output wire              rvalid,
    input  wire              rready,
    // Port pins
    input  wire [WIDTH-1:0]  pin_in,        // Pad levels, asynchronous
    output wire [WIDTH-1:0]  pin_out,       // Output latch to pads
    output wire [WIDTH-1:0]  pin_oe,        // High while pin is driven
    output wire [WIDTH-1:0]  pullup_on,     // Weak pull-up enables
    output wire [WIDTH-1:0]  analog_select_mask, // Analog mode to pads
    output wire              port_change_flag,   // Sticky change flag
    output wire              wake_req       // Wake request to sleep logic
);

    // ======================================================================
    // Storage
    reg  [WIDTH-1:0] pin_meta_reg;          // Synchroniser stage one
    reg  [WIDTH-1:0] pin_sync_reg;          // Synchroniser stage two
    reg  [WIDTH-1:0] out_latch_reg;         // Output data latch
    reg  [WIDTH-1:0] port_direction_mask_reg; // One = input
    reg  [WIDTH-1:0] analog_select_mask_reg;  // One = analog
    reg  [WIDTH-1:0] pullup_enable_mask_reg;  // Per-pin pull-up
    reg  [WIDTH-1:0] change_irq_enable_mask_reg; // Per-pin change detect
    reg  [WIDTH-1:0] last_read_reg;         // Value at last port access
    reg              pullup_global_disable_reg; // Kills all pull-ups
    reg              change_irq_enable_reg; // Lets flag wake the core
    reg              port_change_flag_reg;  // Sticky change flag
    reg  [WIDTH-1:0] pullup_on_reg;         // Registered pull-up drive
    reg              wake_req_reg;          // Registered wake request

    // Bus handshake state
    reg              awready_reg;
    reg              wready_reg;
    reg              aw_full_reg;           // Address held, awaiting data
    reg              w_full_reg;            // Data held, awaiting address
    reg  [4:0]       aw_addr_reg;
    reg  [31:0]      w_data_reg;
    reg              w_lane0_reg;           // Byte lane 0 strobe held
    reg              bvalid_reg;
    reg  [1:0]       bresp_reg;
    reg              arready_reg;
    reg              rvalid_reg;
    reg  [31:0]      rdata_reg;
    reg  [1:0]       rresp_reg;

    // ======================================================================
    // Combinational views
    wire [WIDTH-1:0] port_read_value;       // What a digital read sees
    wire [WIDTH-1:0] mismatch;              // Per-pin change detect
    wire             wr_go;                 // Address and data both held
    wire             rd_go;                 // Read address taken now
    wire             wr_data_hit;           // Write to port data register
    wire             rd_data_hit;           // Read of port data register

    // Analog pins read zero; only synchronised levels are used
    assign port_read_value = pin_sync_reg & ~analog_select_mask_reg;

    // Mismatch against value latched at the last access
    assign mismatch = change_irq_enable_mask_reg
                      & (port_read_value ^ last_read_reg);

    assign wr_go       = aw_full_reg & w_full_reg & ~bvalid_reg;
    assign rd_go       = arvalid & arready_reg;
    assign wr_data_hit = wr_go & w_lane0_reg & (aw_addr_reg == `GPCP_OFS_DATA);
    assign rd_data_hit = rd_go & (araddr == `GPCP_OFS_DATA);

    // ======================================================================
    // Pin synchroniser: stage one feeds stage two only
    always @(posedge aclk) begin
        if (!aresetn) begin
            pin_meta_reg <= `GPCP_ZERO8;
            pin_sync_reg <= `GPCP_ZERO8;
        end else begin
            pin_meta_reg <= pin_in;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // ======================================================================
    // Last-read latch: power-on only, so soft resets leave it alone
    always @(posedge aclk) begin
        if (!aresetn) begin
            last_read_reg <= `GPCP_RST_LATCH;
        end else if (rd_data_hit || wr_data_hit) begin
            // A write samples the pins first, which ends the mismatch too
            last_read_reg <= port_read_value;
        end
    end

    // ======================================================================
    // Configuration registers, set to reset values by either reset
    always @(posedge aclk) begin
        if (!aresetn || !soft_resetn) begin
            out_latch_reg              <= `GPCP_RST_LATCH;
            port_direction_mask_reg    <= `GPCP_RST_DIR;
            analog_select_mask_reg     <= `GPCP_RST_ANSEL;
            pullup_enable_mask_reg     <= `GPCP_RST_PULLUP;
            change_irq_enable_mask_reg <= `GPCP_RST_CHGEN;
            pullup_global_disable_reg  <= `GPCP_RST_PUDIS;
            change_irq_enable_reg      <= 1'b0;
        end else if (wr_go && w_lane0_reg) begin
            case (aw_addr_reg)
                `GPCP_OFS_DATA:   begin
                    // Writes go to the latch, never straight to the pins
                    out_latch_reg <= w_data_reg[WIDTH-1:0];
                end
                `GPCP_OFS_DIR:    begin
                    port_direction_mask_reg <= w_data_reg[WIDTH-1:0];
                end
                `GPCP_OFS_ANSEL:  begin
                    analog_select_mask_reg <= w_data_reg[WIDTH-1:0];
                end
                `GPCP_OFS_PULLUP: begin
                    pullup_enable_mask_reg <= w_data_reg[WIDTH-1:0];
                end
                `GPCP_OFS_CHGEN:  begin
                    change_irq_enable_mask_reg <= w_data_reg[WIDTH-1:0];
                end
                `GPCP_OFS_OPTION: begin
                    pullup_global_disable_reg <= w_data_reg[`GPCP_OPT_PUDIS_BIT];
                end
                `GPCP_OFS_INTCTL: begin
                    change_irq_enable_reg <= w_data_reg[`GPCP_INT_ENA_BIT];
                end
                default: begin
                    // Unmapped: nothing stored
                end
            endcase
        end
    end

    // ======================================================================
    // Change flag: set beats clear, so a live mismatch will not clear
    always @(posedge aclk) begin
        if (!aresetn || !soft_resetn) begin
            port_change_flag_reg <= 1'b0;
        end else if (|mismatch) begin
            // Also covers a change landing on the read edge
            port_change_flag_reg <= 1'b1;
        end else if (wr_go && w_lane0_reg && (aw_addr_reg == `GPCP_OFS_INTCTL)
                     && !w_data_reg[`GPCP_INT_FLAG_BIT]) begin
            // Software clears by writing zero, after ending the mismatch
            port_change_flag_reg <= 1'b0;
        end
    end

    // ======================================================================
    // Pad-side drive, registered so every output is a flop
    always @(posedge aclk) begin
        if (!aresetn || !soft_resetn) begin
            pullup_on_reg <= `GPCP_ZERO8;
            wake_req_reg  <= 1'b0;
        end else begin
            // Pull-up only on inputs, and never when globally disabled
            pullup_on_reg <= pullup_enable_mask_reg & port_direction_mask_reg
                             & {WIDTH{~pullup_global_disable_reg}};
            wake_req_reg  <= port_change_flag_reg & change_irq_enable_reg;
        end
    end

    // ======================================================================
    // AXI4-Lite write channel: address and data in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            awready_reg <= 1'b1;
            wready_reg  <= 1'b1;
            aw_full_reg <= 1'b0;
            w_full_reg  <= 1'b0;
            aw_addr_reg <= 5'h00;
            w_data_reg  <= `GPCP_ZERO32;
            w_lane0_reg <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= `GPCP_RESP_OKAY;
        end else begin
            // Take the address once, hold off further ones
            if (awvalid && awready_reg) begin
                aw_addr_reg <= awaddr;
                aw_full_reg <= 1'b1;
                awready_reg <= 1'b0;
            end
            // Take the data once, hold off further ones
            if (wvalid && wready_reg) begin
                w_data_reg  <= wdata;
                w_lane0_reg <= wstrb[0];
                w_full_reg  <= 1'b1;
                wready_reg  <= 1'b0;
            end
            // Both present: commit and answer
            if (wr_go) begin
                aw_full_reg <= 1'b0;
                w_full_reg  <= 1'b0;
                bvalid_reg  <= 1'b1;
                if (aw_addr_reg <= `GPCP_OFS_INTCTL && aw_addr_reg[1:0] == 2'h0) begin
                    bresp_reg <= `GPCP_RESP_OKAY;
                end else begin
                    bresp_reg <= `GPCP_RESP_SLVERR;
                end
            end
            // Response taken: reopen both channels
            if (bvalid_reg && bready) begin
                bvalid_reg  <= 1'b0;
                awready_reg <= 1'b1;
                wready_reg  <= 1'b1;
            end
        end
    end

    // ======================================================================
    // AXI4-Lite read channel: one read at a time, answer next cycle
    always @(posedge aclk) begin
        if (!aresetn) begin
            arready_reg <= 1'b1;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= `GPCP_ZERO32;
            rresp_reg   <= `GPCP_RESP_OKAY;
        end else begin
            if (rd_go) begin
                arready_reg <= 1'b0;
                rvalid_reg  <= 1'b1;
                rresp_reg   <= `GPCP_RESP_OKAY;
                rdata_reg   <= `GPCP_ZERO32;
                case (araddr)
                    `GPCP_OFS_DATA:   begin
                        rdata_reg[WIDTH-1:0] <= port_read_value;
                    end
                    `GPCP_OFS_DIR:    begin
                        rdata_reg[WIDTH-1:0] <= port_direction_mask_reg;
                    end
                    `GPCP_OFS_ANSEL:  begin
                        rdata_reg[WIDTH-1:0] <= analog_select_mask_reg;
                    end
                    `GPCP_OFS_PULLUP: begin
                        rdata_reg[WIDTH-1:0] <= pullup_enable_mask_reg;
                    end
                    `GPCP_OFS_CHGEN:  begin
                        rdata_reg[WIDTH-1:0] <= change_irq_enable_mask_reg;
                    end
                    `GPCP_OFS_OPTION: begin
                        rdata_reg[`GPCP_OPT_PUDIS_BIT] <= pullup_global_disable_reg;
                    end
                    `GPCP_OFS_INTCTL: begin
                        rdata_reg[`GPCP_INT_FLAG_BIT] <= port_change_flag_reg;
                        rdata_reg[`GPCP_INT_ENA_BIT]  <= change_irq_enable_reg;
                    end
                    default: begin
                        // Unmapped: zero data, error answer
                        rresp_reg <= `GPCP_RESP_SLVERR;
                    end
                endcase
            end
            if (rvalid_reg && rready) begin
                rvalid_reg  <= 1'b0;
                arready_reg <= 1'b1;
            end
        end
    end

    // ======================================================================
    // Outputs, all straight from flops
    assign awready = awready_reg;
    assign wready  = wready_reg;
    assign bvalid  = bvalid_reg;
    assign bresp   = bresp_reg;
    assign arready = arready_reg;
    assign rvalid  = rvalid_reg;
    assign rdata   = rdata_reg;
    assign rresp   = rresp_reg;

    // Latch drives whenever direction is zero, analog or not
    assign pin_out = out_latch_reg;
    assign pin_oe  = ~port_direction_mask_reg;
    assign pullup_on          = pullup_on_reg;
    assign analog_select_mask = analog_select_mask_reg;
    assign port_change_flag   = port_change_flag_reg;
    assign wake_req           = wake_req_reg;

endmodule // gpcp_port

`default_nettype wire

/* File: verif/gpcp_board.sv */
// Board model: external drivers and floating pads on the port pins.
// Assumes the port's pin_out/pin_oe/pullup_on and a bench-set drive.
`timescale 1ns/1ps
`default_nettype none
module gpcp_board #(
    parameter WIDTH = 8                      // Pin count
) (
    input  wire logic             aclk,      // Core clock
    input  wire logic [WIDTH-1:0] pin_out,   // Port output latch
    input  wire logic [WIDTH-1:0] pin_oe,    // Port drive enable
    input  wire logic [WIDTH-1:0] pullup_on, // Weak pull-up enables
    input  wire logic [WIDTH-1:0] ext_en,    // Board driver enables
    input  wire logic [WIDTH-1:0] ext_val,   // Board driver levels
    output var  logic [WIDTH-1:0] pin_in     // Resolved pad levels
);
    // ====
    // Floating pads
    // Undriven pads wander each cycle, so a missing pull-up shows up
    logic [WIDTH-1:0] float_q = '0;
    always @(posedge aclk) begin
        float_q <= ~float_q;
    end
    // Port driver wins, then board, then pull-up, else floating
    always_comb begin
        pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
               | (~pin_oe & ~ext_en & (pullup_on | float_q));
    end
endmodule // gpcp_board
`default_nettype wire

/* File: verif/gpcp_port_chk.sv */
// Checker for the port block: bus holds, pin drive, change flag.
// Assumes a bind onto gpcp_port; it sees the port's bus and pin signals only.
`timescale 1ns/1ps
`default_nettype none
module gpcp_chk #(
    parameter WIDTH = 8                                // Pin count
) (
    input wire logic             aclk,
    input wire logic             aresetn,
    input wire logic             soft_resetn,
    input wire logic             arvalid,
    input wire logic             arready,
    input wire logic [1:0]       bresp,
    input wire logic             bvalid,
    input wire logic             bready,
    input wire logic [31:0]      rdata,
    input wire logic             rvalid,
    input wire logic             rready,
    input wire logic [WIDTH-1:0] pin_out,
    input wire logic [WIDTH-1:0] pin_oe,
    input wire logic [WIDTH-1:0] pullup_on,
    input wire logic [WIDTH-1:0] analog_select_mask,
    input wire logic             port_change_flag,
    input wire logic             wake_req
);
    // ====
    // One clock domain, power-on reset masks everything
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ====
    // Configuration and pins
    AST_SOFT_CFG: assert property (!soft_resetn |=> pin_oe == 8'h00
        && pullup_on == 8'h00 && analog_select_mask == 8'hff)
        else $error("soft reset left config set");
    // Checked only where the pin is driven in both cycles, as pullup_on trails the config
    AST_PULL_OUT: assert property ((pullup_on & pin_oe & $past(pin_oe)) == 8'h00)
        else $error("pull-up on a driven pin");
    AST_LATCH_HOLD: assert property (!$stable(pin_out) |-> $rose(bvalid)
        || !$past(soft_resetn)) else $error("latch moved without a write");
    AST_DIR_HOLD: assert property (!$stable(pin_oe) |-> $rose(bvalid)
        || !$past(soft_resetn)) else $error("drive moved without a write");
    // ====
    // Change flag and wake
    AST_FLAG_STICK: assert property ($fell(port_change_flag) |-> $rose(bvalid)
        || !$past(soft_resetn)) else $error("flag dropped on its own");
    AST_WAKE_FLAG: assert property (wake_req |-> $past(port_change_flag))
        else $error("wake without a flag");
    // ====
    // Register bus answers
    AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write answer not held");
    AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read answer not held");
    AST_R_LAT: assert property (arvalid && arready |=> rvalid)
        else $error("read answer late");
    COV_FLAG: cover property ($rose(port_change_flag));
    COV_WAKE: cover property (wake_req);
    COV_ERR: cover property (bvalid && bresp == 2'h2);
endmodule // gpcp_chk
bind gpcp_port gpcp_chk #(.WIDTH(WIDTH)) i_gpcp_chk (.aclk(aclk), .aresetn(aresetn),
    .soft_resetn(soft_resetn), .arvalid(arvalid), .arready(arready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .rdata(rdata), .rvalid(rvalid), .rready(rready),
    .pin_out(pin_out), .pin_oe(pin_oe), .pullup_on(pullup_on),
    .analog_select_mask(analog_select_mask), .port_change_flag(port_change_flag),
    .wake_req(wake_req));
`default_nettype wire

/* File: verif/test_gpio_port_with_change_irq.sv */
// Self-checking bench for the port block over AXI4-Lite.
// Assumes gpcp_port, gpcp_board and the offsets of gpcp_defs.vh.
`timescale 1ns/1ps
`include "gpcp_defs.vh"
`default_nettype none
module test_gpio_port_with_change_irq;
    // ====
    // Stimulus and observed signals
    logic        aclk = 1'h0, aresetn = 1'h0, soft_resetn = 1'h1;
    logic [4:0]  awaddr = 5'h00, araddr = 5'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'hf;
    logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic        arvalid = 1'h0, rready = 1'h0;
    logic [7:0]  ext_en = 8'h00, ext_val = 8'h00;   // Board drive
    wire logic   awready, wready, bvalid, arready, rvalid, flag, wake;
    wire logic [1:0]  bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [7:0]  pin_in, pin_out, pin_oe, pullup_on, ansel;
    logic [31:0] rd_data;                           // Last read word
    logic [1:0]  rd_resp;                           // Last answer code
    int          error_cnt = 0, checks_done = 0, cycles = 0;
    gpcp_port i_gpcp_port (.aclk(aclk), .aresetn(aresetn), .soft_resetn(soft_resetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .pullup_on(pullup_on),
        .analog_select_mask(ansel), .port_change_flag(flag), .wake_req(wake));
    gpcp_board i_gpcp_board (.aclk(aclk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pullup_on(pullup_on), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
    // ====
    // Clock and hang guard
    initial begin
        forever #50 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 5000) begin // Far beyond the roughly 130 cycles needed
            error_cnt++;
            summarize();
        end
    end
    // ====
    // Shared bus cycles and compare
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        checks_done++;
        if (got !== want) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, want);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'h1;
        wvalid  <= 1'h1;
        bready  <= 1'h1;
        do begin // Each channel is released at its own handshake
            @(posedge aclk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (!bvalid);
        rd_resp = bresp;
        bready <= 1'h0;
        @(posedge aclk); // Keeps back-to-back calls apart
    endtask
    task automatic rd(input logic [4:0] a);
        araddr  <= a;
        arvalid <= 1'h1;
        rready  <= 1'h1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'h0;
        end while (!rvalid);
        rd_data = rdata;
        rd_resp = rresp;
        rready <= 1'h0;
        @(posedge aclk);
    endtask
    // ====
    // Scenarios
    task automatic t_reset;
        logic [4:0] ofs [4] = '{`GPCP_OFS_DIR, `GPCP_OFS_ANSEL,
                                `GPCP_OFS_PULLUP, `GPCP_OFS_CHGEN};
        logic [7:0] rv [4] = '{8'hff, 8'hff, 8'h00, 8'h00};
        for (int i = 0; i < 4; i++) begin
            rd(ofs[i]);
            chk(rd_data, {24'h0, rv[i]});
        end
        rd(`GPCP_OFS_OPTION);
        chk(rd_data[7], 1'h1);
        chk(pin_oe, 8'h00);
        chk(pullup_on, 8'h00);
        chk(ansel, 8'hff);
    endtask
    task automatic t_drive;
        ext_en  <= 8'h0f;
        ext_val <= 8'h03;
        wr(`GPCP_OFS_ANSEL, 32'h0);
        wr(`GPCP_OFS_DIR, 32'h0f);
        wr(`GPCP_OFS_DATA, 32'ha5);
        chk(pin_oe, 8'hf0);
        chk(pin_out, 8'ha5);
        rd(`GPCP_OFS_DATA);
        chk(rd_data, 32'ha3);
        wr(`GPCP_OFS_ANSEL, 32'h81);
        chk(ansel, 8'h81);
        rd(`GPCP_OFS_DATA);
        chk(rd_data, 32'h22);
        chk(pin_out & pin_oe, 8'ha0);
    endtask
    task automatic t_bus;
        wstrb <= 4'h0;
        wr(`GPCP_OFS_DATA, 32'h00);
        wstrb <= 4'hf;
        chk(pin_out, 8'ha5);
        wr(5'h1c, 32'h0);
        chk(rd_resp, 2'h2);
        rd(5'h1c);
        chk({rd_data, rd_resp}, {32'h0, 2'h2});
    endtask
    task automatic t_pull;
        wr(`GPCP_OFS_PULLUP, 32'hff);
        chk(pullup_on, 8'h00);
        wr(`GPCP_OFS_OPTION, 32'h00);
        chk(pullup_on, 8'h0f);
        wr(`GPCP_OFS_OPTION, 32'h80);
        chk(pullup_on, 8'h00);
    endtask
    task automatic t_change;
        wr(`GPCP_OFS_ANSEL, 32'h0);
        wr(`GPCP_OFS_CHGEN, 32'h01);
        rd(`GPCP_OFS_DATA);
        wr(`GPCP_OFS_INTCTL, 32'h08);
        ext_val <= 8'h05; // Only disabled pins move
        repeat (5) @(posedge aclk);
        chk(flag, 1'h0);
        ext_val <= 8'h04;
        repeat (5) @(posedge aclk);
        chk({flag, wake}, 2'h3);
        wr(`GPCP_OFS_INTCTL, 32'h08);
        chk(flag, 1'h1);
        rd(`GPCP_OFS_DATA);
        wr(`GPCP_OFS_INTCTL, 32'h08);
        chk(flag, 1'h0);
    endtask
    task automatic t_soft;
        ext_en  <= 8'hff;
        ext_val <= 8'h5a;
        wr(`GPCP_OFS_DIR, 32'hff);
        rd(`GPCP_OFS_DATA);
        soft_resetn <= 1'h0;
        @(posedge aclk);
        soft_resetn <= 1'h1;
        wr(`GPCP_OFS_ANSEL, 32'h0);
        wr(`GPCP_OFS_CHGEN, 32'hff);
        repeat (4) @(posedge aclk);
        chk(flag, 1'h0);
        ext_val <= 8'h5b; // Synced value reaches the read-address take
        repeat (2) @(posedge aclk);
        rd(`GPCP_OFS_DATA);
        repeat (4) @(posedge aclk);
        chk(flag, 1'h1);
        wr(`GPCP_OFS_INTCTL, 32'h08);
        chk(flag, 1'h0);
    endtask
    task automatic summarize;
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // ====
    // Main sequence
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        t_reset();
        t_drive();
        t_bus();
        t_pull();
        t_change();
        t_soft();
        summarize();
    end
endmodule // test_gpio_port_with_change_irq
`default_nettype wire
